// ---- rtl/bdmm_pkg.sv ----
package bdmm_pkg;

   // ==========================================================
   // Address layout
   localparam int BDMM_ADDR_W   = 12;
   localparam int BDMM_BANK_W   = 5;
   localparam int BDMM_OFS_W    = 7;
   localparam int BDMM_NUM_BANK = 32;
   localparam int BDMM_BANK_SZ  = 128;
   localparam int BDMM_PM_AW    = 15;

   // ==========================================================
   // Offsets inside every bank
   localparam logic [6:0] BDMM_OFS_INDIRECT_PORT_0   = 7'h00;
   localparam logic [6:0] BDMM_OFS_INDIRECT_PORT_1   = 7'h01;
   localparam logic [6:0] BDMM_OFS_PCL     = 7'h02;
   localparam logic [6:0] BDMM_OFS_STATUS  = 7'h03;
   localparam logic [6:0] BDMM_OFS_P0L     = 7'h04;
   localparam logic [6:0] BDMM_OFS_P0H     = 7'h05;
   localparam logic [6:0] BDMM_OFS_P1L     = 7'h06;
   localparam logic [6:0] BDMM_OFS_P1H     = 7'h07;
   localparam logic [6:0] BDMM_OFS_BANKSEL = 7'h08;
   localparam logic [6:0] BDMM_OFS_WACC    = 7'h09;
   localparam logic [6:0] BDMM_OFS_PROGRAM_COUNTER_UPPER_LATCH  = 7'h0A;
   localparam logic [6:0] BDMM_OFS_INTCTL  = 7'h0B;
   localparam logic [6:0] BDMM_OFS_CORE_END = 7'h0B;
   localparam logic [6:0] BDMM_OFS_SFR_LO  = 7'h0C;
   localparam logic [6:0] BDMM_OFS_SFR_HI  = 7'h1F;
   localparam logic [6:0] BDMM_OFS_GPR_LO  = 7'h20;
   localparam logic [6:0] BDMM_OFS_GPR_HI  = 7'h6F;
   localparam logic [6:0] BDMM_OFS_COM_LO  = 7'h70;
   localparam int         BDMM_GPR_BYTES   = 80;
   localparam int         BDMM_COM_BYTES   = 16;
   localparam int         BDMM_PM_SEL_BIT  = 7;
   localparam logic [7:0] BDMM_RST_BYTE    = 8'h00;
   localparam logic [4:0] BDMM_BANK_MASK   = 5'h1F;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       req;
      logic       wr;
      logic       ind;
      logic       sel;
      logic [6:0] ofs;
      logic [7:0] wdata;
   } bdmm_req_t;

   typedef struct packed {
      logic       ack;
      logic       extra;
      logic [7:0] rdata;
   } bdmm_rsp_t;

   typedef enum logic [1:0] {BDMM_IDLE, BDMM_PM_WAIT, BDMM_PM_DONE} bdmm_st_t;

endpackage : bdmm_pkg

// ---- rtl/bdmm_ram.sv ----
module bdmm_ram
   import bdmm_pkg::*;
#(
   parameter int DEPTH = 4096,
   parameter int AW    = 12
) (
   input  wire logic          ref_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);

   // ==========================================================
   // Storage with registered read
   logic [7:0] mem [DEPTH];

   // Write, and present registered read data holding the contents from before the write
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule // bdmm_ram

// ---- rtl/bdmm_pmem_port.sv ----
module bdmm_pmem_port
   import bdmm_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  start,
   input  wire logic [BDMM_PM_AW-1:0] addr_in,
   input  wire logic [13:0]           pm_word,
   output logic      [BDMM_PM_AW-1:0] pm_addr,
   output logic                       pm_rd,
   output logic                       done,
   output logic      [7:0]            byte_out
);

   typedef struct packed {
      bdmm_st_t              st;
      logic [BDMM_PM_AW-1:0] addr;
      logic                  rd;
      logic                  done;
      logic [7:0]            data;
   } bdmm_pm_state_t;

   bdmm_pm_state_t s_r;
   bdmm_pm_state_t s_nxt;

   // Fetch sequencer: two extra cycles to read the word
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      s_nxt.rd   = 1'b0;
      case (s_r.st)
         BDMM_IDLE: begin
            if (start) begin
               s_nxt.addr = addr_in;
               s_nxt.rd   = 1'b1;
               s_nxt.st   = BDMM_PM_WAIT;
            end
         end
         BDMM_PM_WAIT: begin
            s_nxt.data = pm_word[7:0];
            s_nxt.done = 1'b1;
            s_nxt.st   = BDMM_PM_DONE;
         end
         default: begin
            s_nxt.st = BDMM_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_r <= '{st: BDMM_IDLE, addr: '0, rd: 1'b0, done: 1'b0, data: BDMM_RST_BYTE};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pm_addr  = s_r.addr;
   assign pm_rd    = s_r.rd;
   assign done     = s_r.done;
   assign byte_out = s_r.data;

endmodule // bdmm_pmem_port

// ---- rtl/bdmm_map.sv ----
// Summary of operation
// - Pointer high byte bit 7 set makes indirect reads fetch program memory
// - Indirect program memory read returns only the low byte of the word
// - Indirect writes aimed at program memory are discarded
// - Program memory reads via pointer take two extra cycles
// - Data memory is 32 banks of 128 bytes
// - Each bank holds core, 20 special, up to 80 RAM, 16 common bytes
// - Direct accesses use the bank number last written to bank selector
// - Unimplemented locations read as zero
// - All data memory reachable directly and through both file pointers
// - Twelve-bit address: five bank bits above seven offset bits
// - Core registers sit at offsets 0 to 11 of every bank
module bdmm_map
   import bdmm_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire bdmm_req_t              core_req,
   input  wire logic [13:0]            pm_word,
   output bdmm_rsp_t                   core_rsp,
   output logic      [BDMM_PM_AW-1:0]  pm_addr,
   output logic                        pm_rd,
   output logic      [BDMM_ADDR_W-1:0] last_addr,
   output logic                        sfr_we,
   output logic      [BDMM_ADDR_W-1:0] sfr_addr,
   output logic      [7:0]             sfr_wdata,
   input  wire logic [7:0]             sfr_rdata,
   output logic      [7:0]             banksel_q,
   output logic      [7:0]             wacc_q
);

   // ==========================================================
   // Core register bank and response state
   typedef struct packed {
      logic [11:0][7:0]       core;
      logic                   ack;
      logic                   extra;
      logic [7:0]             rdata;
      logic [1:0]             src;
      logic [BDMM_ADDR_W-1:0] last;
      logic                   sfr_we;
      logic [BDMM_ADDR_W-1:0] sfr_addr;
      logic [7:0]             sfr_wdata;
      logic                   pm_busy;
   } bdmm_state_t;

   localparam logic [1:0] SRC_REG  = 2'h0;
   localparam logic [1:0] SRC_RAM  = 2'h1;
   localparam logic [1:0] SRC_SFR  = 2'h2;
   localparam logic [1:0] SRC_ZERO = 2'h3;

   bdmm_state_t s_r;
   bdmm_state_t s_nxt;

   logic [BDMM_ADDR_W-1:0] eff_addr;
   logic [BDMM_BANK_W-1:0] eff_bank;
   logic [BDMM_OFS_W-1:0]  eff_ofs;
   logic [15:0]            ptr;
   logic                   to_pm;
   logic                   ram_we;
   logic [BDMM_ADDR_W-1:0] ram_addr;
   logic [7:0]             ram_rdata;
   logic                   pm_start;
   logic                   pm_done;
   logic [7:0]             pm_byte;
   logic                   accept;

   // ==========================================================
   // Address composition
   // Selected pointer pair for indirect accesses
   always_comb begin
      if (core_req.sel) begin
         ptr = {s_r.core[BDMM_OFS_P1H], s_r.core[BDMM_OFS_P1L]};
      end else begin
         ptr = {s_r.core[BDMM_OFS_P0H], s_r.core[BDMM_OFS_P0L]};
      end
   end

   assign to_pm  = core_req.ind && ptr[8+BDMM_PM_SEL_BIT];
   assign accept = core_req.req && !s_r.pm_busy;

   // Bank from selector for direct, from pointer for indirect
   always_comb begin
      if (core_req.ind) begin
         eff_addr = ptr[BDMM_ADDR_W-1:0];
      end else begin
         eff_addr = {s_r.core[BDMM_OFS_BANKSEL][BDMM_BANK_W-1:0], core_req.ofs};
      end
   end

   assign eff_bank = eff_addr[BDMM_ADDR_W-1:BDMM_OFS_W];
   assign eff_ofs  = eff_addr[BDMM_OFS_W-1:0];

   // Common RAM folds onto bank 0 storage
   always_comb begin
      if (eff_ofs >= BDMM_OFS_COM_LO) begin
         ram_addr = {BDMM_BANK_W'(0), eff_ofs};
      end else begin
         ram_addr = eff_addr;
      end
   end

   assign ram_we   = accept && core_req.wr && !to_pm
                     && eff_ofs >= BDMM_OFS_GPR_LO;
   assign pm_start = accept && !core_req.wr && to_pm;

   // ==========================================================
   // Submodules
   bdmm_ram #(.DEPTH(BDMM_NUM_BANK * BDMM_BANK_SZ), .AW(BDMM_ADDR_W)) u_ram (
      .ref_clk (ref_clk),
      .we      (ram_we),
      .addr    (ram_addr),
      .wdata   (core_req.wdata),
      .rdata   (ram_rdata)
   );

   bdmm_pmem_port u_pm (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .start    (pm_start),
      .addr_in  (ptr[BDMM_PM_AW-1:0]),
      .pm_word  (pm_word),
      .pm_addr  (pm_addr),
      .pm_rd    (pm_rd),
      .done     (pm_done),
      .byte_out (pm_byte)
   );

   // ==========================================================
   // Access sequencing
   always_comb begin
      s_nxt        = s_r;
      s_nxt.ack    = 1'b0;
      s_nxt.extra  = 1'b0;
      s_nxt.sfr_we = 1'b0;
      if (pm_done) begin
         s_nxt.pm_busy = 1'b0;
      end
      if (accept) begin
         s_nxt.last = eff_addr;
         if (to_pm && !core_req.wr) begin
            s_nxt.pm_busy = 1'b1;
         end else if (to_pm) begin
            s_nxt.ack = 1'b1;
            s_nxt.src = SRC_ZERO;
         end else if (eff_ofs <= BDMM_OFS_CORE_END) begin
            s_nxt.ack = 1'b1;
            s_nxt.src = SRC_REG;
            if (eff_ofs == BDMM_OFS_INDIRECT_PORT_0 || eff_ofs == BDMM_OFS_INDIRECT_PORT_1) begin
               s_nxt.rdata = BDMM_RST_BYTE;
            end else begin
               s_nxt.rdata = s_r.core[eff_ofs[3:0]];
            end
            if (core_req.wr && eff_ofs != BDMM_OFS_INDIRECT_PORT_0 && eff_ofs != BDMM_OFS_INDIRECT_PORT_1) begin
               s_nxt.core[eff_ofs[3:0]] = core_req.wdata;
            end
         end else if (eff_ofs <= BDMM_OFS_SFR_HI) begin
            s_nxt.ack       = 1'b1;
            s_nxt.src       = SRC_SFR;
            s_nxt.sfr_we    = core_req.wr;
            s_nxt.sfr_addr  = eff_addr;
            s_nxt.sfr_wdata = core_req.wdata;
         end else begin
            s_nxt.ack = 1'b1;
            s_nxt.src = SRC_RAM;
         end
         if (core_req.wr) begin
            s_nxt.rdata = BDMM_RST_BYTE;
         end
      end
      if (pm_done) begin
         s_nxt.ack   = 1'b1;
         s_nxt.extra = 1'b1;
         s_nxt.rdata = pm_byte;
         s_nxt.src   = SRC_REG;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Read data mux by source
   always_comb begin
      core_rsp.ack   = s_r.ack;
      core_rsp.extra = s_r.extra;
      case (s_r.src)
         SRC_RAM:  core_rsp.rdata = ram_rdata;
         SRC_SFR:  core_rsp.rdata = sfr_rdata;
         SRC_ZERO: core_rsp.rdata = BDMM_RST_BYTE;
         default:  core_rsp.rdata = s_r.rdata;
      endcase
   end

   assign last_addr = s_r.last;
   assign sfr_we    = s_r.sfr_we;
   assign sfr_addr  = s_r.sfr_addr;
   assign sfr_wdata = s_r.sfr_wdata;
   assign banksel_q = s_r.core[BDMM_OFS_BANKSEL];
   assign wacc_q    = s_r.core[BDMM_OFS_WACC];

endmodule // bdmm_map

// ---- bench/bdmm_map_props.sv ----
module bdmm_map_props
   import bdmm_pkg::*;
(
   input wire logic                   ref_clk,
   input wire logic                   rstn,
   input wire bdmm_req_t              core_req,
   input wire logic [13:0]            pm_word,
   input wire bdmm_rsp_t              core_rsp,
   input wire logic [BDMM_PM_AW-1:0]  pm_addr,
   input wire logic                   pm_rd,
   input wire logic [BDMM_ADDR_W-1:0] last_addr,
   input wire logic                   sfr_we,
   input wire logic [BDMM_ADDR_W-1:0] sfr_addr,
   input wire logic [7:0]             sfr_wdata,
   input wire logic [7:0]             sfr_rdata,
   input wire logic [7:0]             banksel_q,
   input wire logic [7:0]             wacc_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] hold_r;
   logic       idle;
   // ==========================================================
   // Fetch tracking
   // Counts the cycles of a fetch in flight, when requests are ignored
   always_ff @(posedge ref_clk) begin
      if (!rstn) hold_r <= 2'h0;
      else if (pm_rd) hold_r <= 2'h2;
      else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
   end
   assign idle = !pm_rd && hold_r == 2'h0;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Sequences
   sequence s_dwr(logic [6:0] o);
      core_req.req && core_req.wr && !core_req.ind && core_req.ofs == o && idle;
   endsequence
   sequence s_fetch;
      pm_rd ##2 core_rsp.ack;
   endsequence
   sequence s_dir;
      core_req.req && !core_req.ind && idle;
   endsequence
   // ==========================================================
   // Assertions
   a_fetch_extra_cycle: assert property (pm_rd |-> ##2 (core_rsp.ack && core_rsp.extra))
      else $error("fetch answer not two cycles after fetch strobe");
   a_extra_from_fetch: assert property (core_rsp.extra |-> $past(pm_rd, 2))
      else $error("extra flag without a program fetch");
   a_fetch_low_byte: assert property (s_fetch |-> core_rsp.rdata == $past(pm_word[7:0], 2))
      else $error("fetched byte is not the low byte of the word");
   a_direct_ack: assert property (s_dir |=> core_rsp.ack && !core_rsp.extra)
      else $error("direct access not answered next cycle");
   a_bank_address: assert property (s_dir |=> last_addr == {$past(banksel_q[4:0]), $past(core_req.ofs)})
      else $error("direct address not bank over offset");
   a_bank_write: assert property (s_dwr(BDMM_OFS_BANKSEL) |=> banksel_q[4:0] == $past(core_req.wdata[4:0]))
      else $error("bank selector not updated");
   a_accum_write: assert property (s_dwr(BDMM_OFS_WACC) |=> wacc_q == $past(core_req.wdata))
      else $error("accumulator not updated");
   a_special_fwd: assert property (core_req.req && core_req.wr && !core_req.ind && idle
      && core_req.ofs inside {[BDMM_OFS_SFR_LO:BDMM_OFS_SFR_HI]}
      |=> sfr_we && sfr_wdata == $past(core_req.wdata) && sfr_addr[6:0] == $past(core_req.ofs))
      else $error("special location write not forwarded");
   a_fetch_single: assert property (pm_rd |=> !pm_rd [*2])
      else $error("second fetch during a fetch");
endmodule // bdmm_map_props

bind bdmm_map bdmm_map_props u_props (.ref_clk(ref_clk), .rstn(rstn), .core_req(core_req),
   .pm_word(pm_word), .core_rsp(core_rsp), .pm_addr(pm_addr), .pm_rd(pm_rd), .last_addr(last_addr),
   .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .banksel_q(banksel_q), .wacc_q(wacc_q));

// ---- bench/bdmm_core_side.sv ----
module bdmm_core_side
   import bdmm_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   pm_rd,
   input  wire logic [BDMM_PM_AW-1:0]  pm_addr,
   output logic      [13:0]            pm_word,
   input  wire logic                   sfr_we,
   input  wire logic [BDMM_ADDR_W-1:0] sfr_addr,
   input  wire logic [7:0]             sfr_wdata,
   output logic      [7:0]             sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  sfr_m [4096];
   initial foreach (sfr_m[i]) sfr_m[i] = 8'h00;
   // Special locations take forwarded writes
   always @(posedge ref_clk) begin
      if (sfr_we) sfr_m[sfr_addr] <= sfr_wdata;
   end
   // Word valid while the fetch strobe stands, inverted otherwise
   assign pm_word = pm_rd ? (pm_addr[13:0] ^ 14'h3A5C) : ~(pm_addr[13:0] ^ 14'h3A5C);
   assign sfr_rdata = sfr_m[sfr_addr];
endmodule // bdmm_core_side

// ---- bench/banked_data_memory_map_bench.sv ----
module banked_data_memory_map_bench;
   import bdmm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic             ref_clk = 1'b0;
   logic             rstn = 1'b0;
   bdmm_req_t        core_req = '0;
   bdmm_rsp_t        core_rsp;
   logic [13:0]      pm_word;
   logic [14:0]      pm_addr, pa;
   logic             pm_rd, sfr_we, ex_q, s;
   logic [11:0]      last_addr, sfr_addr;
   logic [7:0]       sfr_wdata, sfr_rdata, banksel_q, wacc_q, rd_q, lat, d;
   logic [4:0]       b;
   logic [6:0]       o;
   logic [7:0]       refm [logic [11:0]];
   int               seed, errors, total_checks, cyc;
   bdmm_map DUT (.ref_clk(ref_clk), .rstn(rstn), .core_req(core_req), .pm_word(pm_word),
      .core_rsp(core_rsp), .pm_addr(pm_addr), .pm_rd(pm_rd), .last_addr(last_addr), .sfr_we(sfr_we),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .banksel_q(banksel_q),
      .wacc_q(wacc_q));
   bdmm_core_side u_core (.ref_clk(ref_clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_word(pm_word),
      .sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
   initial forever #50 ref_clk = ~ref_clk;
   // Cuts a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 6000) begin
         errors++;
         conclude();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access: pulse the request, wait for the answer
   task automatic acc(input logic w, i, sl, input logic [6:0] of, input logic [7:0] wd);
      @(negedge ref_clk);
      core_req <= '{1'b1, w, i, sl, of, wd};
      @(negedge ref_clk);
      core_req.req <= 1'b0;
      lat = 8'h01;
      while (core_rsp.ack !== 1'b1 && lat < 8'h08) begin
         @(negedge ref_clk);
         lat++;
      end
      rd_q = core_rsp.rdata;
      ex_q = core_rsp.extra;
   endtask
   task automatic bank(input logic [4:0] bn);
      acc(1'b1, 1'b0, 1'b0, BDMM_OFS_BANKSEL, {3'h0, bn});
   endtask
   task automatic ptr(input logic sl, input logic [15:0] p);
      acc(1'b1, 1'b0, 1'b0, sl ? BDMM_OFS_P1L : BDMM_OFS_P0L, p[7:0]);
      acc(1'b1, 1'b0, 1'b0, sl ? BDMM_OFS_P1H : BDMM_OFS_P0H, p[15:8]);
   endtask
   function automatic logic [7:0] pm_exp(input logic [14:0] a);
      return a[7:0] ^ 8'h5C;
   endfunction
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      seed = 28865;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      chk(banksel_q, 16'h0000);
      chk(wacc_q, 16'h0000);
      // Random RAM bytes in random banks, read back both ways
      for (int k = 0; k < 12; k++) begin
         b = $random(seed);
         o = 7'h20 + 7'({$random(seed)} % 80);
         d = $random(seed);
         bank(b);
         acc(1'b1, 1'b0, 1'b0, o, d);
         chk(last_addr, {b, o});
         refm[{b, o}] = d;
      end
      foreach (refm[a]) begin
         s = a[0];
         ptr(s, {4'h0, a});
         acc(1'b0, 1'b1, s, 7'h00, 8'h00);
         chk(rd_q, refm[a]);
         bank(a[11:7]);
         acc(1'b0, 1'b0, 1'b0, a[6:0], 8'h00);
         chk(rd_q, refm[a]);
      end
      $display("test ram done");
      // Common bytes, core registers, special and unimplemented places
      bank(5'h03);
      acc(1'b1, 1'b0, 1'b0, 7'h75, 8'hC3);
      acc(1'b1, 1'b0, 1'b0, BDMM_OFS_WACC, 8'h5A);
      bank(5'h1D);
      acc(1'b0, 1'b0, 1'b0, 7'h75, 8'h00);
      chk(rd_q, 16'h00C3);
      acc(1'b0, 1'b0, 1'b0, BDMM_OFS_WACC, 8'h00);
      chk(rd_q, 16'h005A);
      o = 7'h0C + 7'({$random(seed)} % 20);
      d = $random(seed);
      acc(1'b1, 1'b0, 1'b0, o, d);
      acc(1'b0, 1'b0, 1'b0, o, 8'h00);
      chk(rd_q, d);
      ptr(1'b0, 16'h0080);
      acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
      chk(rd_q, 16'h0000);
      $display("test map done");
      // Program memory through pointer pair 1, writes refused
      for (int k = 0; k < 4; k++) begin
         pa = $random(seed);
         ptr(1'b1, {1'b1, pa});
         acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00);
         chk(rd_q, pm_exp(pa));
         chk(lat, 16'h0003);
         chk(ex_q, 16'h0001);
         acc(1'b1, 1'b1, 1'b1, 7'h00, ~rd_q);
         acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00);
         chk(rd_q, pm_exp(pa));
      end
      $display("test program done");
      conclude();
   end
endmodule // banked_data_memory_map_bench
